// ---- pch_defs.vh ----
// What this block does
// - Request low in user mode restarts configuration
// - Status held low during power-on delay
// - Done held low until loading completes
// - Done rises only after error-free full image
// - Oscillator init: user mode 175-437 us
// - User clock usable four clock periods after done
// - User clock init: delay plus 8576 periods
// - Init-complete output low until initialization ends
// - Serial data pin returns to user I/O
`ifndef PCH_DEFS_VH
`define PCH_DEFS_VH
// ----------------------------------------------------------------
// Timing constants
// ----------------------------------------------------------------
`define PCH_CLK_MHZ          10
`define PCH_POR_US           100
`define PCH_POR_CYC          (`PCH_POR_US * `PCH_CLK_MHZ)
`define PCH_UM_MIN_US        175
`define PCH_UM_MAX_US        437
`define PCH_UM_CYC           (`PCH_UM_MIN_US * `PCH_CLK_MHZ)
`define PCH_CU_PERIODS       4
`define PCH_USR_PERIODS      8576
`define PCH_DONE_EDGES       2
`define PCH_STROBE_NS        250
`define PCH_STROBE_CYC       ((`PCH_STROBE_NS * `PCH_CLK_MHZ + 999) / 1000)
`define PCH_CNT_W            14
`define PCH_IMG_W            32
`define PCH_CNT_ONE          14'h0001
`define PCH_CNT_ZERO         14'h0000
`define PCH_MODE_SERIAL      2'h0
`define PCH_MODE_X8          2'h1
`define PCH_MODE_X16         2'h2
`endif

// ---- pch_passive_config.v ----
`timescale 1ns/1ps
`include "pch_defs.vh"
module pch_passive_config #(
  parameter [31:0] POR_CYC   = `PCH_POR_CYC,
  parameter [31:0] IMG_BITS  = 32'h0000_0100
)(
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_reset_n,
  // Link pins from the host
  input  wire        i_reconfig_request_n,
  input  wire        i_config_clock,
  input  wire        i_serial_config_in,
  input  wire [15:0] i_data_lanes,
  input  wire [1:0]  i_scheme_select_pins,
  // Options
  input  wire        i_user_clock_sel,
  input  wire        i_user_init_clock,
  input  wire        i_init_done_en,
  input  wire        i_data_error,
  // Status outputs
  output reg         o_config_status_n_out,
  output reg         o_config_status_n_oe,
  output reg         o_config_complete,
  output reg         o_init_done_n_oe,
  output reg         o_user_mode,
  output reg         o_serial_pin_user_io
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [5:0] S_POR  = 6'b000001;
  localparam [5:0] S_LOAD = 6'b000010;
  localparam [5:0] S_DONE = 6'b000100;
  localparam [5:0] S_INIT = 6'b001000;
  localparam [5:0] S_USER = 6'b010000;
  localparam [5:0] S_ERR  = 6'b100000;
  localparam [`PCH_CNT_W-1:0] UM_CYC  = `PCH_UM_CYC;
  localparam [`PCH_CNT_W-1:0] USR_CYC = `PCH_USR_PERIODS;
  localparam [`PCH_CNT_W-1:0] CU_CYC  = `PCH_CU_PERIODS;
  localparam [1:0] EDGES = `PCH_DONE_EDGES;

  reg [5:0]             state_q;
  reg [31:0]            por_q;
  reg [`PCH_IMG_W-1:0]  bits_q;
  reg [`PCH_CNT_W-1:0]  cnt_q;
  reg [1:0]             fall_q;
  reg [2:0]             req_s, config_clock_s, din_s, uclk_s;
  reg [1:0]             mode_s1, mode_s2;
  reg [1:0]             err_s, usel_s, ien_s;
  reg                   err_q;
  reg                   armed_q;

  // ----------------------------------------------------------------
  // Synchronisers; third stage feeds edge detection, or the unused_in tie-off for din_s
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      req_s  <= 3'h7;
      config_clock_s <= 3'h0;
      din_s  <= 3'h0;
      uclk_s <= 3'h0;
    end
    else
    begin
      req_s  <= {req_s[1:0], i_reconfig_request_n};
      config_clock_s <= {config_clock_s[1:0], i_config_clock};
      din_s  <= {din_s[1:0], i_serial_config_in};
      uclk_s <= {uclk_s[1:0], i_user_init_clock};
    end
  end

  // ----------------------------------------------------------------
  // Option and scheme pins; static in use, but still two flops deep
  // ----------------------------------------------------------------
  // A pin that moves mid-load must not reach the counters half settled
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      mode_s1 <= `PCH_MODE_SERIAL;
      mode_s2 <= `PCH_MODE_SERIAL;
      err_s   <= 2'h0;
      usel_s  <= 2'h0;
      ien_s   <= 2'h0;
    end
    else
    begin
      mode_s1 <= i_scheme_select_pins;
      mode_s2 <= mode_s1;
      err_s   <= {err_s[0], i_data_error};
      usel_s  <= {usel_s[0], i_user_clock_sel};
      ien_s   <= {ien_s[0], i_init_done_en};
    end
  end

  wire [1:0] mode_sync = mode_s2;
  wire       err_sync  = err_s[1];
  wire       usel_sync = usel_s[1];
  wire       ien_sync  = ien_s[1];

  wire req_lo   = ~req_s[1];
  wire config_clock_ris = config_clock_s[1] & ~config_clock_s[2];
  wire config_clock_fal = ~config_clock_s[1] & config_clock_s[2];
  wire uclk_ris = uclk_s[1] & ~uclk_s[2];
  // Bits per rising edge by scheme; lanes beyond the width are ignored
  wire [`PCH_IMG_W-1:0] step = (mode_sync == `PCH_MODE_X16) ? 32'h0000_0010 :
                               (mode_sync == `PCH_MODE_X8)  ? 32'h0000_0008 :
                                                                         32'h0000_0001;
  wire unused_in = din_s[2] ^ ^i_data_lanes;

  // ----------------------------------------------------------------
  // Configuration sequence
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q <= S_POR;
      por_q   <= 32'h0000_0000;
      bits_q  <= 32'h0000_0000;
      cnt_q   <= `PCH_CNT_ZERO;
      fall_q  <= 2'h0;
      err_q   <= 1'b0;
      armed_q <= 1'b0;
    end
    else if (req_lo && state_q != S_POR)
    begin
      state_q <= S_LOAD;
      bits_q  <= 32'h0000_0000;
      err_q   <= 1'b0;
    end
    else
    begin
      case (state_q)
        S_POR:
        begin
          if (por_q >= POR_CYC - 32'h0000_0001)
            state_q <= S_LOAD;
          else
            por_q <= por_q + 32'h0000_0001;
        end
        S_LOAD:
        begin
          if (config_clock_ris)
          begin
            bits_q <= bits_q + step;
            if (err_sync | unused_in & 1'b0)
              err_q <= 1'b1;
          end
          if (err_q)
            state_q <= S_ERR;
          else if (bits_q >= IMG_BITS)
          begin
            state_q <= S_DONE;
            fall_q  <= 2'h0;
            armed_q <= 1'b0;
            cnt_q   <= `PCH_CNT_ZERO;
          end
        end
        S_DONE:
        begin
          // Two falling config-clock edges start initialization; a fall
          // counts only after a rise seen in this state, so the fall that
          // closes the last data beat cannot stand in for one of the two
          if (config_clock_ris)
            armed_q <= 1'b1;
          if (config_clock_fal && armed_q)
          begin
            armed_q <= 1'b0;
            fall_q  <= fall_q + 2'h1;
            if (fall_q == EDGES - 2'h1)
              state_q <= S_INIT;
          end
        end
        S_INIT:
        begin
          // Count from the second counted config-clock fall: oscillator path or user clock path
          if (!usel_sync)
          begin
            cnt_q <= cnt_q + `PCH_CNT_ONE;
            if (cnt_q >= UM_CYC - `PCH_CNT_ONE)
              state_q <= S_USER;
          end
          else if (uclk_ris)
          begin
            cnt_q <= cnt_q + `PCH_CNT_ONE;
            if (cnt_q >= USR_CYC + CU_CYC - `PCH_CNT_ONE)
              state_q <= S_USER;
          end
        end
        S_USER:  state_q <= S_USER;
        S_ERR:   state_q <= S_ERR;
        default: state_q <= S_POR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registered pin outputs
  // ----------------------------------------------------------------
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_config_status_n_out <= 1'b0;
      o_config_status_n_oe  <= 1'b1;
      o_config_complete     <= 1'b0;
      o_init_done_n_oe      <= 1'b0;
      o_user_mode           <= 1'b0;
      o_serial_pin_user_io  <= 1'b0;
    end
    else
    begin
      // Open drain: drive low in reset delay, on error, or while request is low
      o_config_status_n_oe  <= (state_q == S_POR) | (state_q == S_ERR) | req_lo;
      o_config_status_n_out <= 1'b0;
      o_config_complete     <= (state_q == S_DONE) | (state_q == S_INIT) |
                               (state_q == S_USER);
      o_init_done_n_oe      <= ien_sync & (state_q != S_USER) &
                               (state_q != S_POR);
      o_user_mode           <= (state_q == S_USER);
      o_serial_pin_user_io  <= (state_q == S_USER);
    end
  end
endmodule

// ---- pch_host.sv ----
`timescale 1ns/1ps
// ----
// Host model
// ----
module pch_host (
  output logic        o_cclk,
  output logic        o_sdat,
  output logic [15:0] o_lanes
);
  // Clock rests low outside frames
  initial
  begin
    o_cclk = 1'b0;
    o_sdat = 1'b0;
    o_lanes = 16'h0000;
  end
  // One word per beat; data idles inverted so a stale bit never looks fresh
  task automatic beat(input int n);
    #23;
    repeat (n)
    begin
      o_sdat = ~o_sdat;
      o_lanes = ~o_lanes;
      #400 o_cclk = 1'b1;
      #400 o_cclk = 1'b0;
    end
    o_sdat = ~o_sdat;
    o_lanes = ~o_lanes;
  endtask
endmodule

// ---- pch_passive_config_chk.sv ----
`timescale 1ns/1ps
`include "pch_defs.vh"
// ----
// Handshake checker
// ----
module pch_chk (
  input wire logic i_clk, i_reset_n, i_reconfig_request_n, i_init_done_en, i_user_clock_sel,
  input wire logic o_config_status_n_oe, o_config_complete, o_init_done_n_oe, o_user_mode, o_serial_pin_user_io
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  localparam int UM_MIN  = `PCH_UM_MIN_US * `PCH_CLK_MHZ;
  localparam int UM_MAX  = `PCH_UM_MAX_US * `PCH_CLK_MHZ;
  localparam int UMC_MIN = 2 * (`PCH_USR_PERIODS + `PCH_CU_PERIODS);
  // Cycles since done rose; frozen in user mode so the rise can be judged
  int since_done;
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      since_done <= 0;
    else if (!o_config_complete)
      since_done <= 0;
    else if (!o_user_mode)
      since_done <= since_done + 1;
  end
  property p_por; $rose(i_reset_n) |-> o_config_status_n_oe [*6]; endproperty
  a_por: assert property (p_por) else $error("status early");
  property p_req; $fell(i_reconfig_request_n) |-> ##[1:5] !o_config_complete; endproperty
  a_req: assert property (p_req) else $error("no restart");
  property p_ok; $rose(o_config_complete) |-> !o_config_status_n_oe; endproperty
  a_ok: assert property (p_ok) else $error("done with error");
  // Error holds status low and keeps done down
  property p_err; o_config_status_n_oe && i_reconfig_request_n |-> !o_config_complete; endproperty
  a_err: assert property (p_err) else $error("done in error");
  property p_gate; $rose(o_user_mode) |-> o_config_complete; endproperty
  a_gate: assert property (p_gate) else $error("early user mode");
  // Init time is long, so a counter measures it instead of a deep past
  property p_um;
    $rose(o_user_mode) && !i_user_clock_sel |-> since_done >= UM_MIN && since_done <= UM_MAX;
  endproperty
  a_um: assert property (p_um) else $error("init time out of window");
  // A synchronised user clock yields at most one counted edge per two cycles
  property p_umc; $rose(o_user_mode) && i_user_clock_sel |-> since_done >= UMC_MIN; endproperty
  a_umc: assert property (p_umc) else $error("user clock init too short");
  property p_init; $rose(o_user_mode) && i_init_done_en |-> $fell(o_init_done_n_oe); endproperty
  a_init: assert property (p_init) else $error("init pin");
  property p_io; $rose(o_serial_pin_user_io) |-> $rose(o_user_mode); endproperty
  a_io: assert property (p_io) else $error("pin early");
  c_done: cover property ($rose(o_config_complete));
  c_um: cover property ($rose(o_user_mode));
  c_req: cover property ($fell(i_reconfig_request_n));
endmodule
bind pch_passive_config pch_chk i_pch_chk (.i_clk, .i_reset_n, .i_reconfig_request_n, .i_init_done_en, .i_user_clock_sel,
  .o_config_status_n_oe, .o_config_complete, .o_init_done_n_oe, .o_user_mode, .o_serial_pin_user_io);

// ---- tb.sv ----
`timescale 1ns/1ps
`include "pch_defs.vh"
// ----
// Bench
// ----
module tb;
  logic i_clk = 0, i_reset_n = 0, rq_n = 1, err = 0, usel = 0, ien = 1;
  logic [1:0] ud = 2'h0;
  logic [1:0] mode = 2'h0;
  logic cclk, sdat;
  logic [15:0] lanes;
  wire st, sto, done, ido, um, uio;
  int errors = 0, check_count = 0;
  always #50 i_clk = ~i_clk;
  // User init clock: four bench cycles a period, moved on the edge
  always @(posedge i_clk) ud <= ud + 2'h1;
  pch_host i_pch_host (.o_cclk(cclk), .o_sdat(sdat), .o_lanes(lanes));
  // Small counts keep the run short
  pch_passive_config #(.POR_CYC(8), .IMG_BITS(16)) i_pch_passive_config (.i_clk, .i_reset_n,
    .i_reconfig_request_n(rq_n), .i_config_clock(cclk), .i_serial_config_in(sdat), .i_data_lanes(lanes),
    .i_scheme_select_pins(mode), .i_user_clock_sel(usel), .i_user_init_clock(ud[1]), .i_init_done_en(ien),
    .i_data_error(err), .o_config_status_n_out(sto), .o_config_status_n_oe(st), .o_config_complete(done),
    .o_init_done_n_oe(ido), .o_user_mode(um), .o_serial_pin_user_io(uio));
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #10;
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic results;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_req;
    rq_n = 0;
    cyc(5);
    chk("done", 1'b0, done);
    chk("um", 1'b0, um);
    rq_n = 1;
    cyc(14);
  endtask
  // Serial load one bit short, then whole, then initialise
  task automatic t_serial;
    chk("st", 1'b1, st);
    cyc(12);
    chk("st", 1'b0, st);
    i_pch_host.beat(15);
    cyc(6);
    chk("done", 1'b0, done);
    i_pch_host.beat(1);
    cyc(6);
    chk("done", 1'b1, done);
    i_pch_host.beat(2);
    cyc(1700);
    chk("um", 1'b0, um);
    chk("ido", 1'b1, ido);
    cyc(100);
    chk("um", 1'b1, um);
    chk("uio", 1'b1, uio);
    chk("ido", 1'b0, ido);
  endtask
  // Wide loads; an error blocks done
  task automatic t_wide;
    mode = 2'h1;
    i_pch_host.beat(2);
    cyc(6);
    chk("done", 1'b1, done);
    t_req();
    mode = 2'h2;
    err = 1;
    i_pch_host.beat(1);
    cyc(6);
    chk("done", 1'b0, done);
    chk("st", 1'b1, st);
    err = 0;
    t_req();
    i_pch_host.beat(1);
    cyc(6);
    chk("done", 1'b1, done);
  endtask
  // User-clock initialisation with the init-done option off
  task automatic t_uclk;
    usel = 1;
    ien = 0;
    chk("st", 1'b0, st);
    i_pch_host.beat(2);
    cyc(4 * (`PCH_USR_PERIODS + `PCH_CU_PERIODS) - 120);
    chk("um", 1'b0, um);
    chk("ido", 1'b0, ido);
    cyc(240);
    chk("um", 1'b1, um);
    chk("uio", 1'b1, uio);
    chk("st", 1'b0, st);
    chk("sto", 1'b0, sto);
  endtask
  initial
  begin
    cyc(3);
    i_reset_n = 1;
    t_serial();
    t_req();
    t_wide();
    t_uclk();
    results();
  end
  initial
  begin
    // Both init waits with margin; the user-clock one dominates
    #6000000;
    errors++;
    results();
  end
endmodule
